//--- design/rtcs_slave.v
/*
 two-wire serial slave access logic of a real-time clock.
 assumes the register file sits outside: writes leave through a fifo of
 address/data words, reads are answered combinationally on rd_addr/rd_data.
 the bus pins are raw and asynchronous; sda is open drain (oe high pulls low).
*/
// Behaviour
// - write address plus zero direction bit, acked on ninth clock, enters write.
// - second byte low five bits are register address, upper three transfer mode.
// - each written byte acked while the write queue has room, more accepted; write ends on stop, any start, timeout, backup or a full queue.
// - read-direction address acked, then device drives register data bytes.
// - master ack low gets next byte; no ack ends read before stop.
// - direct read starts at internal pointer, which resets to register zero.
// - time registers held from start to stop.
// - half a second after start the access aborts and hold releases.
// - repeated start does not restart the timeout.
// - bus interface disabled in battery backup mode; counters keep running.
// - other pins stay active in backup mode unless a control bit disables.
// - power-on reset leaves time counting registers untouched.
// - pulses under 50 ns on clock and data are rejected.
// - ack after matching address, register address and each write byte the queue accepts.
// - address bit zero is direction, one read; upper seven the device address.
`timescale 1ns/1ns
`include "rtcs_consts.vh"
module rtcs_slave #(
    parameter [6:0]  DEV_ADDR = `RTCS_DEV_ADDR,
    parameter [31:0] TMO_CYC  = `RTCS_TMO_CYC,
    parameter        FDEPTH   = 8
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    input  wire       backup_mode,
    output wire       time_hold,
    output wire [4:0] wr_addr,
    output wire [7:0] wr_data,
    output wire [2:0] wr_mode,
    output wire       wr_valid,
    input  wire       wr_ready,
    output reg  [4:0] rd_addr,
    input  wire [7:0] rd_data,
    output reg        busy
);
    // byte engine states
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_REG  = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_RDAT = 3'h4;
    localparam ST_MACK = 3'h5;
    localparam ST_SKIP = 3'h6;

    // filtered lines, edge marks and bus conditions
    wire        scl;
    wire        sda;
    reg         scl_d;
    reg         sda_d;
    reg  [2:0]  state;
    reg  [3:0]  bitn;
    reg  [7:0]  shreg;
    reg  [7:0]  txreg;
    reg         ack_slot;
    reg         drive_low;
    reg  [2:0]  mode;
    reg  [31:0] tmo;
    wire        fifo_ready;
    reg         push;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_c;
    wire        stop_c;
    wire        timeout;
    wire [7:0]  rx_byte;

    // glitch filters; backup mode forces lines idle so the bus is unseen
    rtcs_filter #(.LEN(`RTCS_GLITCH_CYC)) u_scl (
        .clk   (clk),
        .rst   (rst),
        .pin   (scl_in | backup_mode),
        .level (scl)
    );
    rtcs_filter #(.LEN(`RTCS_GLITCH_CYC)) u_sda (
        .clk   (clk),
        .rst   (rst),
        .pin   (sda_in | backup_mode),
        .level (sda)
    );

    // write words queue toward the register file
    // backup mode idles the bus lines and byte engine but not the queue, so the queue keeps draining
    rtcs_fifo #(.WIDTH(16), .DEPTH(FDEPTH), .AW(3)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   ({mode, rd_addr, shreg}),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .out_data  ({wr_mode, wr_addr, wr_data}),
        .out_valid (wr_valid),
        .out_ready (wr_ready)
    );

    // previous filtered levels for edge and condition detection
    always @(posedge clk)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // conditions need scl high on two samples, so data moving while scl is low is never a start
    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    assign start_c  = scl & scl_d & sda_d & ~sda;
    assign stop_c   = scl & scl_d & ~sda_d & sda;
    assign timeout  = busy && (tmo >= TMO_CYC - 32'h1);
    assign rx_byte  = {shreg[6:0], sda};

    // open-drain data: only ever pulls low
    // drive_low is registered, so sda moves one clock after the filtered fall
    assign sda_out   = 1'b0;
    assign sda_oe    = drive_low & ~backup_mode;
    // time registers frozen while a transaction is open; the counters live outside
    assign time_hold = busy;

    // transaction window and timeout counted from the first start only
    always @(posedge clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            tmo  <= 32'h0;
        end
        else if (stop_c || timeout || backup_mode)
        begin
            busy <= 1'b0;
            tmo  <= 32'h0;
        end
        // only the first start opens the window; a repeated start leaves tmo running
        else if (start_c && !busy)
        begin
            busy <= 1'b1;
            tmo  <= 32'h0;
        end
        // no wrap: the window closes long before tmo could overflow
        else if (busy)
            tmo <= tmo + 32'h1;
    end

    // byte engine: shift on rising scl, act on falling scl
    // the ack slot is the ninth clock; bitn counts rises within a byte
    always @(posedge clk)
    begin
        if (rst)
        begin
            state     <= ST_IDLE;
            bitn      <= 4'h0;
            shreg     <= 8'h00;
            txreg     <= 8'h00;
            ack_slot  <= 1'b0;
            drive_low <= 1'b0;
            mode      <= 3'h0;
            rd_addr   <= `RTCS_PTR_RST;
            push      <= 1'b0;
        end
        else
        begin
            // push is a one-clock strobe
            push <= 1'b0;
            if (timeout || stop_c || backup_mode)
            begin
                state     <= ST_IDLE;
                drive_low <= 1'b0;
                ack_slot  <= 1'b0;
            end
            // any start, first or repeated, rewinds the byte engine
            else if (start_c)
            begin
                state     <= ST_ADDR;
                bitn      <= 4'h0;
                ack_slot  <= 1'b0;
                drive_low <= 1'b0;
            end
            // the ninth rise is skipped while the device owns the line
            else if (scl_rise && !ack_slot)
            begin
                shreg <= rx_byte;
                bitn  <= bitn + 4'h1;
                if (state == ST_MACK && sda)
                    state <= ST_SKIP;
            end
            else if (scl_fall)
            begin
                if (ack_slot)
                begin
                    // ninth clock over: release or load the next read byte
                    ack_slot  <= 1'b0;
                    bitn      <= 4'h0;
                    drive_low <= 1'b0;
                    if (state == ST_RDAT)
                    begin
                        txreg     <= {rd_data[6:0], 1'b0};
                        drive_low <= ~rd_data[7];
                    end
                end
                else
                begin
                    case (state)
                    ST_ADDR:
                    begin
                        if (bitn == 4'h8)
                        begin
                            // address byte complete: answer only our own address
                            if (shreg[7:1] == DEV_ADDR)
                            begin
                                ack_slot  <= 1'b1;
                                drive_low <= 1'b1;
                                state     <= shreg[`RTCS_RW_BIT] ? ST_RDAT : ST_REG;
                            end
                            else
                                state <= ST_SKIP;
                        end
                    end
                    ST_REG:
                    begin
                        if (bitn == 4'h8)
                        begin
                            // register byte: pointer and mode for the words that follow
                            rd_addr   <= shreg[`RTCS_REG_MSB:`RTCS_REG_LSB];
                            mode      <= shreg[`RTCS_MODE_MSB:`RTCS_MODE_LSB];
                            ack_slot  <= 1'b1;
                            drive_low <= 1'b1;
                            state     <= ST_WDAT;
                        end
                    end
                    ST_WDAT:
                    begin
                        if (bitn == 4'h8)
                        begin
                            // no ack while the queue is full; master sees a nack
                            if (fifo_ready)
                            begin
                                push      <= 1'b1;
                                ack_slot  <= 1'b1;
                                drive_low <= 1'b1;
                            end
                            else
                                state <= ST_SKIP;
                        end
                    end
                    ST_RDAT:
                    begin
                        if (bitn == 4'h8)
                        begin
                            // release for master ack, step the pointer
                            drive_low <= 1'b0;
                            rd_addr   <= rd_addr + 5'h01;
                            state     <= ST_MACK;
                        end
                        else
                        begin
                            // bits six down to zero leave on the following falls
                            drive_low <= ~txreg[7];
                            txreg     <= {txreg[6:0], 1'b0};
                        end
                    end
                    ST_MACK:
                    begin
                        // master acked low: next byte goes out
                        if (bitn == 4'h9)
                        begin
                            bitn      <= 4'h0;
                            txreg     <= {rd_data[6:0], 1'b0};
                            drive_low <= ~rd_data[7];
                            state     <= ST_RDAT;
                        end
                    end
                    // idle and skip: stay off the line until the next start or stop
                    default:
                        drive_low <= 1'b0;
                    endcase
                end
            end
            // the pointer steps once per byte written, after the word is queued
            if (push)
                rd_addr <= rd_addr + 5'h01;
        end
    end
endmodule

//--- design/rtcs_consts.vh
/*
 constants for the rtc serial slave access block: address fields, byte layout,
 timing figures at a 10 MHz core clock. no processes, definitions only.
*/
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH

// core clock period in ns
`define RTCS_CLK_NS          100
// device address, arbitrary neutral value
`define RTCS_DEV_ADDR        7'h2a
// register address and mode fields of the second byte
`define RTCS_REG_MSB         4
`define RTCS_REG_LSB         0
`define RTCS_MODE_MSB        7
`define RTCS_MODE_LSB        5
// direction bit of the address byte
`define RTCS_RW_BIT          0
// reset value of the internal pointer
`define RTCS_PTR_RST         5'h00
// transaction timeout in ms and its cycle count (rounded down)
`define RTCS_TMO_MS          500
`define RTCS_TMO_CYC         ((`RTCS_TMO_MS * 1000000) / `RTCS_CLK_NS)
// glitch suppression in ns and cycles (rounded up, at least one)
`define RTCS_GLITCH_NS       50
`define RTCS_GLITCH_CYC      ((`RTCS_GLITCH_NS + `RTCS_CLK_NS - 1) / `RTCS_CLK_NS)

`endif

//--- design/rtcs_filter.v
/*
 two-stage synchroniser followed by a majority-free stability filter for one bus line.
 assumes the raw pin is asynchronous to clk; output changes only after the
 synchronised value has differed from it on LEN+1 samples in a row.
*/
`timescale 1ns/1ns
module rtcs_filter #(
    parameter LEN = 1
) (
    input  wire clk,
    input  wire rst,
    input  wire pin,
    output reg  level
);
    reg       meta;
    reg       sync;
    reg [3:0] cnt;

    // synchroniser, first stage read only by the second
    always @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b1;
            sync <= 1'b1;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
        end
    end

    // a pulse caught by a single clock edge never reaches the output
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt   <= 4'h0;
            level <= 1'b1;
        end
        else if (sync == level)
            cnt <= 4'h0;
        else if (cnt >= LEN[3:0])
        begin
            cnt   <= 4'h0;
            level <= sync;
        end
        else
            cnt <= cnt + 4'h1;
    end
endmodule

//--- design/rtcs_fifo.v
/*
 synchronous fifo with valid/ready on both sides, width and depth as parameters.
 assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ns
module rtcs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            empty;
    wire            full;
    wire            push;
    wire            pop;
    wire [AW-1:0]   head_idx;

    // full and empty from pointers with a wrap bit
    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign push      = in_valid & ~full;
    assign pop       = out_ready & ~empty;

    // storage and pointers
    always @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always @(posedge clk)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    // head word shown from a flip-flop; a word pushed into the head slot goes
    // straight through, so out_data is never stale while out_valid is high
    assign head_idx = pop ? rd_ptr[AW-1:0] + {{(AW-1){1'b0}}, 1'b1} : rd_ptr[AW-1:0];

    always @(posedge clk)
    begin
        if (rst)
            out_data <= {WIDTH{1'b0}};
        else if (push && (wr_ptr[AW-1:0] == head_idx))
            out_data <= in_data;
        else
            out_data <= mem[head_idx];
    end
endmodule

//--- verification/rtcs_checker.sv
/*
 checker for rtcs_slave: hold flag, timeout, backup mode, pointer and fifo head.
 assumes it is bound into rtcs_slave and sees only its ports.
*/
`timescale 1ns/1ns
module rtcs_checker #(
    parameter [31:0] TMO_CYC = 2000
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe,
    input wire logic       backup_mode,
    input wire logic       time_hold,
    input wire logic       busy,
    input wire logic [4:0] rd_addr,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] wr_mode,
    input wire logic       wr_valid,
    input wire logic       wr_ready
);
    logic [31:0] busy_cnt;

    // length of the current busy stretch
    always_ff @(posedge clk)
    begin
        if (rst || !busy)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= busy_cnt + 32'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_hold_busy; $rose(time_hold) |-> !sda_in; endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("hold rose without sda low");
    property p_busy_start; $rose(busy) |-> scl_in; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy rose without start");
    property p_tmo; busy |-> busy_cnt <= TMO_CYC + 32'h1; endproperty
    a_tmo: assert property (p_tmo) else $error("busy outlived timeout");
    property p_backup_oe; backup_mode |-> !sda_oe; endproperty
    a_backup_oe: assert property (p_backup_oe) else $error("sda driven in backup");
    property p_backup_idle; backup_mode && $past(backup_mode) |-> !busy; endproperty
    a_backup_idle: assert property (p_backup_idle) else $error("busy in backup");
    property p_ptr_idle; !busy && !$past(busy) |-> $stable(rd_addr); endproperty
    a_ptr_idle: assert property (p_ptr_idle) else $error("pointer moved while idle");
    property p_wr_hold; wr_valid && !wr_ready |=> wr_valid && $stable({wr_mode, wr_addr, wr_data}); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("fifo head changed");
    property p_idle_quiet; !busy && !$past(busy) && !$past(busy, 2) |-> !sda_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");

    c_read: cover property (busy && sda_oe && !scl_in);
    c_stall: cover property (wr_valid && !wr_ready ##1 wr_valid);
    c_tmo: cover property (busy_cnt > TMO_CYC - 32'h20);
endmodule

bind rtcs_slave rtcs_checker #(.TMO_CYC(TMO_CYC)) u_chk (
    .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe), .backup_mode(backup_mode),
    .time_hold(time_hold), .busy(busy), .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mode(wr_mode), .wr_valid(wr_valid), .wr_ready(wr_ready)
);

//--- verification/rtcs_master.sv
/*
 behavioural two-wire bus master for the slave's pins.
 assumes a pull-up on sda; scl idles high between frames.
*/
`timescale 1ns/1ns
module rtcs_master (
    input  wire logic clk,
    input  wire logic sda_oe,
    output logic      scl,
    output wire logic sda
);
    int   q     = 7;    // quarter bit in clocks: start hold and low time above bus minimums
    logic m_low = 1'b0;

    // pulled-up line, low while either party pulls
    assign sda = !(m_low || sda_oe);
    initial scl = 1'b1;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // data set while scl low, sampled in the high phase
    task automatic bit_io(input logic b, output logic r);
        m_low = !b;
        tick(q);
        scl = 1'b1;
        tick(q);
        r = sda;
        tick(q);
        scl = 1'b0;
        tick(q);
    endtask

    // start or repeated start: sda falls while scl high
    task automatic start;
        m_low = 1'b0;
        tick(q);
        scl = 1'b1;
        tick(q);
        m_low = 1'b1;
        tick(q);
        scl = 1'b0;
        tick(q);
    endtask

    // stop only after a complete byte and its ninth bit
    task automatic stop;
        m_low = 1'b1;
        tick(q);
        scl = 1'b1;
        tick(q);
        m_low = 1'b0;
        tick(q);
    endtask

    // msb first, then the ninth bit; ack_in high releases the line
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack);
    endtask
endmodule

//--- verification/test_rtcs_serial_slave_access.sv
/*
 testbench for rtcs_slave with a behavioural bus master and a register image.
 assumes rtcs_master and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
module test_rtcs_serial_slave_access;
    localparam int         TMO = 4000;
    localparam logic [6:0] DEV = 7'h2a;  // arbitrary device address

    logic       clk = 1'b0;
    logic       rst, backup_mode, wr_ready, glitch;
    logic       scl, sda, sda_out, sda_oe, time_hold, wr_valid, busy;
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data;
    logic [2:0] wr_mode;
    logic [7:0] mem [32];
    int         failures = 0, n_tests = 0, cyc = 0;

    // clock, cycle count and register image
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    assign rd_data = mem[rd_addr];

    rtcs_master m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    rtcs_slave #(.DEV_ADDR(DEV), .TMO_CYC(TMO)) dut (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda && !glitch), .sda_out(sda_out),
        .sda_oe(sda_oe), .backup_mode(backup_mode), .time_hold(time_hold), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_mode(wr_mode), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy)
    );

    function automatic logic [15:0] word_exp(input logic [2:0] md, input logic [4:0] ad, input logic [7:0] dt);
        return {md, ad, dt};
    endfunction

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic nack);
        logic [7:0] rx;
        logic       ak;
        m.xfer(b, 1'b1, rx, ak);
        chk("ack", ak, nack);
    endtask

    task automatic recv(input logic ack_in, input logic [7:0] exp);
        logic [7:0] rx;
        logic       ak;
        m.xfer(8'hff, ack_in, rx, ak);
        chk("read byte", rx, exp);
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        logic [4:0] a;
        logic [2:0] md;
        logic [7:0] d [9];
        int         t, c0, k;
        rst = 1'b1;
        backup_mode = 1'b0;
        wr_ready = 1'b0;
        glitch = 1'b0;
        a = $urandom(32'h7cf6);
        foreach (mem[i])
            mem[i] = $urandom;
        md = $urandom;
        m.tick(10);
        rst = 1'b0;
        m.tick(2);
        chk("busy", busy, 1'b0);
        chk("pointer", rd_addr, 5'h00);
        chk("wr_valid", wr_valid, 1'b0);
        $display("test reset done");
        m.start();
        send({DEV, 1'b1}, 1'b0);
        for (int i = 0; i < 3; i++)
            recv(i == 2, mem[i]);
        chk("hold", time_hold, 1'b1);
        m.stop();
        m.tick(8);
        chk("hold", time_hold, 1'b0);
        $display("test direct read done");
        m.start();
        send({DEV, 1'b0}, 1'b0);
        send({md, a}, 1'b0);
        for (int i = 0; i < 9; i++)
        begin
            d[i] = $urandom;
            send(d[i], i == 8);
        end
        m.stop();
        // drain with a random ready; each word is compared before the edge that pops it
        k = 0;
        t = 0;
        while (k < 8 && t < 400)
        begin
            wr_ready = 1'($urandom);
            if (wr_valid === 1'b1 && wr_ready)
            begin
                chk("word", {wr_mode, wr_addr, wr_data}, word_exp(md, a + 5'(k), d[k]));
                k++;
            end
            m.tick(1);
            t++;
        end
        wr_ready = 1'b0;
        chk("words", 16'(k), 16'h0008);
        m.tick(3);
        chk("wr_valid", wr_valid, 1'b0);
        $display("test fifo fill done");
        m.q = 12;
        m.start();
        send({DEV, 1'b0}, 1'b0);
        send({md, a}, 1'b0);
        m.start();
        send({DEV, 1'b1}, 1'b0);
        recv(1'b0, mem[a]);
        recv(1'b1, mem[a + 5'h1]);
        m.stop();
        m.q = 7;
        $display("test addressed read done");
        m.start();
        send({DEV ^ 7'h01, 1'b0}, 1'b1);
        send(8'h00, 1'b1);
        m.stop();
        chk("wr_valid", wr_valid, 1'b0);
        // random backup pulse on an idle bus: nothing may open
        backup_mode = 1'($urandom);
        m.tick(3);
        backup_mode = 1'b0;
        m.tick(1);
        chk("busy", busy, 1'b0);
        backup_mode = 1'b1;
        m.start();
        send({DEV, 1'b0}, 1'b1);
        chk("busy", busy, 1'b0);
        m.stop();
        backup_mode = 1'b0;
        m.tick(2);
        // 40 ns low pulse on sda while scl is high, straddling a clock edge
        #60 glitch = 1'b1;
        #40 glitch = 1'b0;
        m.tick(6);
        chk("busy", busy, 1'b0);
        $display("test refusals done");
        c0 = cyc;
        m.start();
        send({DEV, 1'b0}, 1'b0);
        send({md, a}, 1'b0);
        m.start();
        send({DEV, 1'b1}, 1'b0);
        t = 0;
        while (busy === 1'b1 && t < TMO + 100)
        begin
            m.tick(1);
            t++;
        end
        t = cyc - c0 - 2 * m.q;
        chk("timeout", t >= TMO && t <= TMO + 8, 1'b1);
        send({DEV, 1'b0}, 1'b1);
        m.stop();
        $display("test timeout done");
        test_done();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #6000000;
        failures++;
        test_done();
    end
endmodule
